// File: hdl/ppc_cfg.svh
// Offsets, field positions, reset values and sizes of the pin control block
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

`define PPC_NPINS 4
`define PPC_AW 4
`define PPC_SYNC_STAGES 2

`define PPC_OFF_PULL 4'h0
`define PPC_OFF_SLEW 4'h1
`define PPC_OFF_DRIVE 4'h2
`define PPC_OFF_SC 4'h3
`define PPC_OFF_POL 4'h4
`define PPC_OFF_PSEL 4'h5
`define PPC_OFF_EVT_STS 4'h6
`define PPC_OFF_EVT_EN 4'h7
`define PPC_OFF_EVT_CLR 4'h8

`define PPC_SC_FLAG 3
`define PPC_SC_ACK 2
`define PPC_SC_IE 1
`define PPC_SC_MOD 0

`define PPC_RST_CTRL 4'h0
`define PPC_RST_SC 8'h00
`define PPC_RST_RDATA 8'h00

`endif

// File: hdl/ppc_pkg.sv
// Types shared by the pin control block
`include "ppc_cfg.svh"
package ppc_pkg;

    typedef logic [`PPC_NPINS-1:0] ppc_pins_t;

    // Per-pin pad controls, one bit per pin in each field
    typedef struct packed {
        ppc_pins_t pull_en;
        ppc_pins_t pull_down;
        ppc_pins_t slew_en;
        ppc_pins_t drive_hi;
    } ppc_pad_t;

    // Read image of the interrupt status/control register
    typedef struct packed {
        logic [3:0] zero;
        logic flag;
        logic ack;
        logic ie;
        logic mode;
    } ppc_sc_t;

endpackage

// File: hdl/ppc_sync.sv
// Multi-bit two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module ppc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // The first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule

// File: hdl/ppc_top.sv
// Pad control and pin-interrupt logic for a four-pin port
//
// Notes on behaviour
// - Bits 7:4 ignore writes, read zero
// - Pull-enable bit turns pin pull on
// - Output pins never get a pull
// - Pull-down only with polarity and pin-select set
// - Slew bit limits slew, outputs only
// - Drive bit: 0 low, 1 high drive, outputs only
// - Detect flag shows detection, ignores writes
// - Acknowledge write clears flag, reads zero
// - Request only when enable and flag set
// - Mode bit: 0 edges, 1 edges and levels
// - Polarity: 0 falling/low, 1 rising/high
// - Only selected pins take part
// - Active edge or level sets flag
// - Asserted level keeps flag through acknowledge
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_top (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [`PPC_AW-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [`PPC_NPINS-1:0] PIN_I,
    input wire logic [`PPC_NPINS-1:0] PIN_DIR_I,
    output ppc_pkg::ppc_pad_t PAD_O,
    output logic PORT_IRQ_O,
    output logic EVT_IRQ_O
);
    import ppc_pkg::*;

    localparam int NP = `PPC_NPINS;
    localparam logic [7:0] SC_RST = `PPC_RST_SC;

    ppc_pins_t pull_reg;
    ppc_pins_t slew_reg;
    ppc_pins_t drive_reg;
    ppc_pins_t pol_reg;
    ppc_pins_t psel_reg;
    ppc_pins_t evt_sts_reg;
    ppc_pins_t evt_sts_next;
    ppc_pins_t evt_en_reg;
    ppc_pins_t pin_s;
    ppc_pins_t pin_prev_reg;
    ppc_pins_t lvl_act;
    ppc_pins_t prev_act;
    ppc_pins_t edge_hit;
    ppc_pins_t lvl_hit;
    ppc_pins_t pd_allow;
    logic flag_reg;
    logic flag_next;
    logic ie_reg;
    logic mod_reg;
    logic set_evt;
    logic ack_wr;
    logic irq_cond;
    logic [7:0] rdata_reg;
    logic [7:0] rd_next;
    ppc_pad_t pad_reg;
    ppc_pad_t pad_next;
    ppc_sc_t sc_view;
    logic port_irq_reg;
    logic evt_irq_reg;
    logic wr_pull;
    logic wr_slew;
    logic wr_drive;
    logic wr_sc;
    logic wr_pol;
    logic wr_psel;
    logic wr_evt_en;
    logic wr_evt_clr;

    // Register write decode
    assign wr_pull = WR_I && (ADDR_I == `PPC_OFF_PULL);
    assign wr_slew = WR_I && (ADDR_I == `PPC_OFF_SLEW);
    assign wr_drive = WR_I && (ADDR_I == `PPC_OFF_DRIVE);
    assign wr_sc = WR_I && (ADDR_I == `PPC_OFF_SC);
    assign wr_pol = WR_I && (ADDR_I == `PPC_OFF_POL);
    assign wr_psel = WR_I && (ADDR_I == `PPC_OFF_PSEL);
    assign wr_evt_en = WR_I && (ADDR_I == `PPC_OFF_EVT_EN);
    assign wr_evt_clr = WR_I && (ADDR_I == `PPC_OFF_EVT_CLR);
    assign ack_wr = wr_sc && WDATA_I[`PPC_SC_ACK];

    // Pad control registers keep only bits 3:0
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pull_reg <= `PPC_RST_CTRL;
            slew_reg <= `PPC_RST_CTRL;
            drive_reg <= `PPC_RST_CTRL;
        end else begin
            if (wr_pull) begin
                pull_reg <= WDATA_I[NP-1:0];
            end
            if (wr_slew) begin
                slew_reg <= WDATA_I[NP-1:0];
            end
            if (wr_drive) begin
                drive_reg <= WDATA_I[NP-1:0];
            end
        end
    end

    // Interrupt pin configuration
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pol_reg <= `PPC_RST_CTRL;
            psel_reg <= `PPC_RST_CTRL;
        end else begin
            if (wr_pol) begin
                pol_reg <= WDATA_I[NP-1:0];
            end
            if (wr_psel) begin
                psel_reg <= WDATA_I[NP-1:0];
            end
        end
    end

    // Interrupt control bits; the flag itself is not writable
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ie_reg <= SC_RST[`PPC_SC_IE];
            mod_reg <= SC_RST[`PPC_SC_MOD];
        end else if (wr_sc) begin
            ie_reg <= WDATA_I[`PPC_SC_IE];
            mod_reg <= WDATA_I[`PPC_SC_MOD];
        end
    end

    // Pad drive; outputs follow the registers one cycle later
    assign pd_allow = pol_reg & psel_reg;

    always_comb begin
        pad_next.pull_en = pull_reg & ~PIN_DIR_I;
        // A pull-down is only legal for a polarity-high interrupt pin
        pad_next.pull_down = pad_next.pull_en & pd_allow;
        pad_next.slew_en = slew_reg & PIN_DIR_I;
        pad_next.drive_hi = drive_reg & PIN_DIR_I;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pad_reg <= '0;
        end else begin
            pad_reg <= pad_next;
        end
    end

    // Pins cross into the bus clock before any detection
    ppc_sync #(
        .WIDTH(NP)
    ) u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .d_i(PIN_I),
        .q_o(pin_s)
    );

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_prev_reg <= '0;
        end else begin
            pin_prev_reg <= pin_s;
        end
    end

    // Active sense per pin; both samples use the current polarity, so a polarity change alone is no edge
    assign lvl_act = pin_s ~^ pol_reg;
    assign prev_act = pin_prev_reg ~^ pol_reg;
    assign edge_hit = psel_reg & lvl_act & ~prev_act;
    assign lvl_hit = mod_reg ? (psel_reg & lvl_act) : '0;
    assign set_evt = (|edge_hit) || (|lvl_hit);

    // Set beats acknowledge; in level mode an asserted pin re-sets it
    always_comb begin
        flag_next = flag_reg;
        if (set_evt) begin
            flag_next = 1'b1;
        end else if (ack_wr) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag_reg <= SC_RST[`PPC_SC_FLAG];
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Per-pin edge events, sticky; set wins over a clear
    assign evt_sts_next = (evt_sts_reg & ~(wr_evt_clr ? WDATA_I[NP-1:0]
        : '0)) | edge_hit;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            evt_sts_reg <= `PPC_RST_CTRL;
            evt_en_reg <= `PPC_RST_CTRL;
        end else begin
            evt_sts_reg <= evt_sts_next;
            if (wr_evt_en) begin
                evt_en_reg <= WDATA_I[NP-1:0];
            end
        end
    end

    // Interrupt outputs lag their cause by one cycle
    assign irq_cond = ie_reg && flag_reg;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            port_irq_reg <= 1'b0;
            evt_irq_reg <= 1'b0;
        end else begin
            port_irq_reg <= irq_cond;
            evt_irq_reg <= |(evt_sts_reg & evt_en_reg);
        end
    end

    // Read path; unmapped and write-only locations read zero
    always_comb begin
        sc_view = '0;
        sc_view.flag = flag_reg;
        sc_view.ack = 1'b0;
        sc_view.ie = ie_reg;
        sc_view.mode = mod_reg;
        case (ADDR_I)
            `PPC_OFF_PULL: rd_next = {4'h0, pull_reg};
            `PPC_OFF_SLEW: rd_next = {4'h0, slew_reg};
            `PPC_OFF_DRIVE: rd_next = {4'h0, drive_reg};
            `PPC_OFF_SC: rd_next = sc_view;
            `PPC_OFF_POL: rd_next = {4'h0, pol_reg};
            `PPC_OFF_PSEL: rd_next = {4'h0, psel_reg};
            `PPC_OFF_EVT_STS: rd_next = {4'h0, evt_sts_reg};
            `PPC_OFF_EVT_EN: rd_next = {4'h0, evt_en_reg};
            default: rd_next = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_reg <= `PPC_RST_RDATA;
        end else if (RD_I) begin
            rdata_reg <= rd_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign RDATA_O = rdata_reg;
    assign PAD_O = pad_reg;
    assign PORT_IRQ_O = port_irq_reg;
    assign EVT_IRQ_O = evt_irq_reg;

    // Checks; the age counter keeps $past clear of reset values
    logic [1:0] age_reg;
    logic aged;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end

    assign aged = (age_reg == 2'h3);

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_resv_read: assert property (
        (RDATA_O[7:4] == 4'h0)
    ) else $error("reserved bits read non-zero");

    a_pull_follows: assert property (
        aged && wr_pull && (PIN_DIR_I == 4'h0) ##1 (PIN_DIR_I == 4'h0)
        |=> (PAD_O.pull_en == $past(WDATA_I[3:0], 2))
    ) else $error("pull enable does not follow its register");

    a_no_pull_out: assert property (
        aged |-> ((PAD_O.pull_en & $past(PIN_DIR_I)) == 4'h0)
    ) else $error("pull active on an output pin");

    a_pulldown_gate: assert property (
        aged |-> ((PAD_O.pull_down & ~$past(pd_allow)) == 4'h0)
    ) else $error("pull-down without polarity and pin select");

    a_slew_inputs: assert property (
        aged |-> ((PAD_O.slew_en & ~$past(PIN_DIR_I)) == 4'h0)
    ) else $error("slew control active on an input pin");

    a_drive_sel: assert property (
        aged |-> (PAD_O.drive_hi == ($past(drive_reg) & $past(PIN_DIR_I)))
    ) else $error("drive strength not as selected");

    a_flag_nowrite: assert property (
        wr_sc && !WDATA_I[2] && !set_evt |=> $stable(flag_reg)
    ) else $error("direct write changed the detect flag");

    a_ack_reads0: assert property (
        RD_I && (ADDR_I == `PPC_OFF_SC) |=> !RDATA_O[2]
    ) else $error("acknowledge bit read as one");

    a_ack_clears: assert property (
        ack_wr && !set_evt |=> !flag_reg
    ) else $error("acknowledge did not clear the flag");

    a_irq_request: assert property (
        aged |-> (PORT_IRQ_O == ($past(ie_reg) && $past(flag_reg)))
    ) else $error("port request not enable and flag");

    a_edge_only: assert property (
        !mod_reg && !flag_reg && (edge_hit == 4'h0) |=> !flag_reg
    ) else $error("flag set with no edge in edge mode");

    a_unselected: assert property (
        (psel_reg == 4'h0) && !flag_reg |=> !flag_reg
    ) else $error("unselected pin set the flag");

    a_event_sets: assert property (
        set_evt |=> flag_reg [*1] ##0 (sc_view.flag)
    ) else $error("active event did not set the flag");

    a_level_holds: assert property (
        mod_reg && ((psel_reg & lvl_act) != 4'h0) && ack_wr |=> flag_reg
    ) else $error("acknowledge cleared flag on asserted level");

    a_sync_delay: assert property (
        aged |-> (pin_s == $past(PIN_I, 2))
    ) else $error("pin sample not two cycles old");

    c_edge_flag: cover property (!flag_reg && !mod_reg ##1 flag_reg);
    c_level_keep: cover property (mod_reg && ack_wr ##1 flag_reg);
    c_irq_rise: cover property ($rose(PORT_IRQ_O));
    c_pull_down: cover property (PAD_O.pull_down != 4'h0);

endmodule

// File: sim/ppc_ext_pins.sv
// Model of the external circuitry that sits on the four port pins
`timescale 1ns/1ps
module ppc_ext_pins (
    input wire logic clk_i,
    input wire logic [3:0] drive_en_i,
    input wire logic [3:0] drive_val_i,
    input wire ppc_pkg::ppc_pad_t pad_i,
    output logic [3:0] pin_o
);
    import ppc_pkg::*;
    logic [3:0] wobble = 4'h5;

    // A floating pin changes every cycle so no held value can pass as real
    always @(posedge clk_i) begin
        wobble <= ~wobble;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (drive_en_i[i]) begin
                pin_o[i] = drive_val_i[i];
            end else if (pad_i.pull_en[i]) begin
                pin_o[i] = ~pad_i.pull_down[i];
            end else begin
                pin_o[i] = wobble[i];
            end
        end
    end
endmodule

// File: sim/ppc_top_test.sv
// Self-checking bench for the pad control and pin-interrupt block
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_top_test;
    import ppc_pkg::*;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [`PPC_AW-1:0] ADDR_I = 4'h0;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic [7:0] RDATA_O;
    logic [`PPC_NPINS-1:0] PIN_I;
    logic [`PPC_NPINS-1:0] PIN_DIR_I = 4'h0;
    ppc_pad_t PAD_O;
    logic PORT_IRQ_O;
    logic EVT_IRQ_O;
    logic [3:0] ext_en = 4'hF;
    logic [3:0] ext_val = 4'hB;
    int bad_count = 0;
    int checks_done = 0;
    integer seed = 32'hd3a7;
    logic [31:0] r;
    logic [7:0] d;
    logic [15:0] got;

    always #50 CLK_I = ~CLK_I;

    ppc_top uut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .PIN_I(PIN_I), .PIN_DIR_I(PIN_DIR_I), .PAD_O(PAD_O),
        .PORT_IRQ_O(PORT_IRQ_O), .EVT_IRQ_O(EVT_IRQ_O));

    ppc_ext_pins far_side (.clk_i(CLK_I), .drive_en_i(ext_en),
        .drive_val_i(ext_val), .pad_i(PAD_O), .pin_o(PIN_I));

    function automatic logic [15:0] exp_pad(input logic [3:0] p, s, v, e,
        q, dir);
        logic [3:0] en;
        en = p & ~dir;
        return {en, en & e & q, s & dir, v & dir};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= v;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge CLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 v = RDATA_O;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    task automatic pins(input logic [3:0] v);
        @(posedge CLK_I);
        ext_val <= v;
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bounded wait: the request must show a few cycles after the pin edge
    task automatic wait_irq;
        int i;
        i = 0;
        while (PORT_IRQ_O !== 1'b1 && i < 10) begin
            cyc(1);
            i++;
        end
        if (PORT_IRQ_O !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask

    initial begin
        repeat (2) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rdchk(a[3:0], 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            @(posedge CLK_I);
            PIN_DIR_I <= r[23:20];
            wr(`PPC_OFF_PULL, {r[31:28], r[3:0]});
            wr(`PPC_OFF_SLEW, {r[27:24], r[7:4]});
            wr(`PPC_OFF_DRIVE, {r[31:28], r[11:8]});
            wr(`PPC_OFF_POL, {r[27:24], r[15:12]});
            wr(`PPC_OFF_PSEL, {r[31:28], r[19:16]});
            rdchk(`PPC_OFF_PULL, {4'h0, r[3:0]});
            rdchk(`PPC_OFF_SLEW, {4'h0, r[7:4]});
            rdchk(`PPC_OFF_DRIVE, {4'h0, r[11:8]});
            got = PAD_O;
            chk(got, exp_pad(r[3:0], r[7:4], r[11:8], r[15:12], r[19:16],
                r[23:20]));
        end
        wr(4'hF, 8'hFF);
        rdchk(4'hF, 8'h00);
        @(posedge CLK_I);
        PIN_DIR_I <= 4'h0;
        wr(`PPC_OFF_PULL, 8'h0F);
        wr(`PPC_OFF_POL, 8'h04);
        wr(`PPC_OFF_PSEL, 8'h05);
        wr(`PPC_OFF_EVT_EN, 8'h00);
        cyc(4);
        wr(`PPC_OFF_EVT_CLR, 8'h0F);
        wr(`PPC_OFF_SC, 8'hFE);
        cyc(3);
        rdchk(`PPC_OFF_SC, 8'h02);
        chk({15'h0, PORT_IRQ_O}, 16'h0000);
        pins(4'h9);
        cyc(5);
        rdchk(`PPC_OFF_SC, 8'h02);
        pins(4'hB);
        cyc(3);
        pins(4'hA);
        wait_irq();
        rdchk(`PPC_OFF_SC, 8'h0A);
        rd(`PPC_OFF_EVT_STS, d);
        chk({15'h0, d[0]}, 16'h0001);
        wr(`PPC_OFF_EVT_EN, 8'h01);
        cyc(2);
        chk({15'h0, EVT_IRQ_O}, 16'h0001);
        wr(`PPC_OFF_EVT_CLR, 8'h01);
        cyc(2);
        chk({15'h0, EVT_IRQ_O}, 16'h0000);
        wr(`PPC_OFF_SC, 8'h06);
        cyc(2);
        chk({15'h0, PORT_IRQ_O}, 16'h0000);
        rdchk(`PPC_OFF_SC, 8'h02);
        pins(4'hB);
        cyc(5);
        rdchk(`PPC_OFF_SC, 8'h02);
        wr(`PPC_OFF_SC, 8'h00);
        pins(4'hA);
        cyc(6);
        chk({15'h0, PORT_IRQ_O}, 16'h0000);
        rdchk(`PPC_OFF_SC, 8'h08);
        wr(`PPC_OFF_SC, 8'h02);
        cyc(2);
        chk({15'h0, PORT_IRQ_O}, 16'h0001);
        wr(`PPC_OFF_SC, 8'h07);
        cyc(3);
        rdchk(`PPC_OFF_SC, 8'h0B);
        pins(4'hB);
        cyc(4);
        wr(`PPC_OFF_SC, 8'h07);
        cyc(3);
        rdchk(`PPC_OFF_SC, 8'h03);
        wr(`PPC_OFF_SC, 8'h06);
        cyc(3);
        pins(4'hF);
        wait_irq();
        rdchk(`PPC_OFF_SC, 8'h0A);
        // Acknowledge in level mode while the pin stays asserted: no dip
        wr(`PPC_OFF_SC, 8'h03);
        wr(`PPC_OFF_SC, 8'h07);
        cyc(1);
        chk({15'h0, PORT_IRQ_O}, 16'h0001);
        cyc(1);
        chk({15'h0, PORT_IRQ_O}, 16'h0001);
        rdchk(`PPC_OFF_SC, 8'h0B);
        final_report();
    end
endmodule
